// ==== src/pwc_engine.v ====
// Purpose: Serial write command engine of a two-wiper digital potentiometer
// Assumes: SCL and SDA sampled by the 40 MHz core clock; Avalon-MM slave
// Notes: Read data phases are not served; read commands only set the pointer
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_defines.vh"

module pwc_engine #(
  parameter [5:0] SLAVE_ADDR_HI = 6'h2A,
  parameter integer NV_WRITE_CYCLES = `PWC_TWC_CYCLES
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_lowest_slave_address_bit,
  input wire i_high_voltage_command_pin,
  output reg o_sda_out,
  output reg o_sda_oe,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg [8:0] o_wiper0,
  output reg [8:0] o_wiper1,
  output reg [8:0] o_terminal_control_register,
  output reg o_eeprom_write_active_flag
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CTRL = 5'h02;
  localparam [4:0] ST_CMD = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_ERR = 5'h10;

  wire [3:0] pins_sync;
  reg scl_q, sda_q;
  reg [4:0] state, next_state;
  reg [4:0] ack_state;
  reg next_ack;
  reg [3:0] bitcnt;
  reg in_ack;
  reg [7:0] shreg;
  reg [3:0] cmd_addr;
  reg cmd_d8;
  reg [3:0] rd_ptr;
  reg lock0, lock1, protect;
  reg pend;
  reg [1:0] pend_kind;
  reg [3:0] pend_addr;
  reg [8:0] pend_data;
  reg busy;
  reg [31:0] cyc_cnt;
  reg mem_we;
  wire [8:0] mem_rdata;
  reg cfg_eight_bit;
  reg [1:0] ph;
  reg [31:0] rd_mux;

  // Pins pass two flops before any logic looks at them
  pwc_sync2 #(.WIDTH(4)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_high_voltage_command_pin, i_lowest_slave_address_bit, i_sda, i_scl}),
    .o_sync(pins_sync)
  );

  wire s_scl = pins_sync[0];
  wire s_sda = pins_sync[1];
  wire s_a0 = pins_sync[2];
  wire s_hv = pins_sync[3];
  // The high level on the shared pin also reads as a one in address bit 0
  wire a0_eff = s_hv | s_a0;
  wire scl_rise = s_scl & ~scl_q;
  wire scl_fall = ~s_scl & scl_q;
  wire bus_start = scl_q & s_scl & sda_q & ~s_sda;
  wire bus_stop = scl_q & s_scl & ~sda_q & s_sda;
  wire [8:0] full_scale = cfg_eight_bit ? `PWC_FULL_8BIT : `PWC_FULL_7BIT;

  // Non-volatile locations: both wipers' stores and the data cells
  function is_nv;
    input [3:0] ad;
    begin
      is_nv = (ad == `PWC_AD_NVWIPER0) | (ad == `PWC_AD_NVWIPER1) | (ad > `PWC_AD_STATUS);
    end
  endfunction

  // Address and command check against locks, protect and programming
  function cmd_ok;
    input [3:0] ad;
    input [1:0] c;
    input hv, l0, l1, wp, bsy;
    reg nv, lockhit;
    begin
      nv = is_nv(ad);
      lockhit = (((ad == `PWC_AD_VWIPER0) | (ad == `PWC_AD_NVWIPER0)) & l0) |
                (((ad == `PWC_AD_VWIPER1) | (ad == `PWC_AD_NVWIPER1)) & l1);
      case (c)
        `PWC_CMD_WRITE: begin
          // Locked wiper refused at any voltage, protect guards stores
          cmd_ok = (ad != `PWC_AD_STATUS) & ~(nv & bsy) & ~lockhit & ~(nv & wp);
        end
        `PWC_CMD_INC, `PWC_CMD_DEC: begin
          if (ad == `PWC_AD_VWIPER0 || ad == `PWC_AD_VWIPER1) begin
            cmd_ok = ~lockhit;
          end else if (hv && (ad == `PWC_AD_NVWIPER0 || ad == `PWC_AD_NVWIPER1 ||
                              ad == `PWC_AD_PROTECT)) begin
            cmd_ok = ~bsy;
          end else begin
            cmd_ok = 1'b0;
          end
        end
        default: begin
          cmd_ok = ~(nv & bsy) & (hv | ~lockhit);
        end
      endcase
    end
  endfunction

  // Saturating one-step wiper move
  function [8:0] step;
    input [8:0] w;
    input up;
    input [8:0] full;
    begin
      if (up) begin
        step = (w < full) ? w + 9'h001 : w;
      end else begin
        step = (w != 9'h000) ? w - 9'h001 : w;
      end
    end
  endfunction

  // Acknowledge decision for the byte just shifted in
  always @* begin
    next_ack = 1'b0;
    next_state = state;
    case (state)
      ST_CTRL: begin
        if (shreg[7:1] == {SLAVE_ADDR_HI, a0_eff} && !shreg[0]) begin
          next_ack = 1'b1;
          next_state = ST_CMD;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_CMD: begin
        // Any byte after a stored non-volatile write is an error
        if (!pend && cmd_ok(shreg[7:4], shreg[3:2], s_hv, lock0, lock1, protect, busy)) begin
          next_ack = 1'b1;
          next_state = (shreg[3:2] == `PWC_CMD_WRITE) ? ST_DATA : ST_CMD;
        end else begin
          next_state = ST_ERR;
        end
      end
      ST_DATA: begin
        next_ack = 1'b1;
        next_state = ST_CMD;
      end
      default: begin
        next_state = state;
      end
    endcase
  end

  // Serial engine, command execution and programming cycle
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      ack_state <= ST_IDLE;
      bitcnt <= 4'h0;
      in_ack <= 1'b0;
      shreg <= 8'h00;
      cmd_addr <= 4'h0;
      cmd_d8 <= 1'b0;
      rd_ptr <= 4'h0;
      lock0 <= 1'b0;
      lock1 <= 1'b0;
      protect <= 1'b0;
      pend <= 1'b0;
      pend_kind <= `PWC_KIND_DATA;
      pend_addr <= 4'h0;
      pend_data <= 9'h000;
      busy <= 1'b0;
      cyc_cnt <= 32'h00000000;
      mem_we <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wiper0 <= `PWC_WIPER_RST;
      o_wiper1 <= `PWC_WIPER_RST;
      o_terminal_control_register <= `PWC_TERMINAL_CONTROL_REGISTER_RST;
      o_eeprom_write_active_flag <= 1'b0;
    end else begin
      scl_q <= s_scl;
      sda_q <= s_sda;
      mem_we <= 1'b0;
      // Programming cycle countdown; results land at its end
      if (busy) begin
        if (cyc_cnt == 32'h00000000) begin
          busy <= 1'b0;
          o_eeprom_write_active_flag <= 1'b0;
          case (pend_kind)
            `PWC_KIND_LOCK_SET: begin
              lock0 <= lock0 | (pend_addr == `PWC_AD_NVWIPER0);
              lock1 <= lock1 | (pend_addr == `PWC_AD_NVWIPER1);
              protect <= protect | (pend_addr == `PWC_AD_PROTECT);
            end
            `PWC_KIND_LOCK_CLR: begin
              lock0 <= lock0 & (pend_addr != `PWC_AD_NVWIPER0);
              lock1 <= lock1 & (pend_addr != `PWC_AD_NVWIPER1);
              protect <= protect & (pend_addr != `PWC_AD_PROTECT);
            end
            default: begin
              mem_we <= 1'b1;
            end
          endcase
        end else begin
          cyc_cnt <= cyc_cnt - 32'h00000001;
        end
      end
      if (bus_start) begin
        // Start or Restart drops anything unfinished, error included
        state <= ST_CTRL;
        bitcnt <= 4'h0;
        in_ack <= 1'b0;
        o_sda_oe <= 1'b0;
        pend <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        bitcnt <= 4'h0;
        in_ack <= 1'b0;
        o_sda_oe <= 1'b0;
        pend <= 1'b0;
        if (pend && !busy) begin
          busy <= 1'b1;
          o_eeprom_write_active_flag <= 1'b1;
          cyc_cnt <= NV_WRITE_CYCLES - 1;
        end
      end else if (state != ST_IDLE) begin
        if (scl_rise && !in_ack && bitcnt < 4'h8) begin
          shreg <= {shreg[6:0], s_sda};
          bitcnt <= bitcnt + 4'h1;
        end
        // Acknowledge clock: the acked byte takes effect now
        if (scl_rise && in_ack && o_sda_oe) begin
          if (state == ST_CMD) begin
            cmd_addr <= shreg[7:4];
            cmd_d8 <= shreg[0];
            case (shreg[3:2])
              `PWC_CMD_INC, `PWC_CMD_DEC: begin
                if (shreg[7:4] == `PWC_AD_VWIPER0) begin
                  o_wiper0 <= step(o_wiper0, shreg[2], full_scale);
                end else if (shreg[7:4] == `PWC_AD_VWIPER1) begin
                  o_wiper1 <= step(o_wiper1, shreg[2], full_scale);
                end else begin
                  // Decrement enables, increment disables
                  pend <= 1'b1;
                  pend_addr <= shreg[7:4];
                  pend_kind <= shreg[2] ? `PWC_KIND_LOCK_CLR : `PWC_KIND_LOCK_SET;
                end
              end
              `PWC_CMD_READ: begin
                rd_ptr <= shreg[7:4];
              end
              default: begin
                rd_ptr <= shreg[7:4];
              end
            endcase
          end else if (state == ST_DATA) begin
            if (cmd_addr == `PWC_AD_VWIPER0) begin
              o_wiper0 <= {cmd_d8, shreg};
            end else if (cmd_addr == `PWC_AD_VWIPER1) begin
              o_wiper1 <= {cmd_d8, shreg};
            end else if (cmd_addr == `PWC_AD_TERMINAL_CONTROL_REGISTER) begin
              o_terminal_control_register <= {cmd_d8, shreg};
            end else begin
              pend <= 1'b1;
              pend_kind <= `PWC_KIND_DATA;
              pend_addr <= cmd_addr;
              pend_data <= {cmd_d8, shreg};
            end
          end
        end
        if (scl_fall) begin
          if (in_ack) begin
            // Release after the acknowledge clock
            in_ack <= 1'b0;
            o_sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            state <= ack_state;
          end else if (bitcnt == 4'h8 && state != ST_ERR) begin
            in_ack <= 1'b1;
            o_sda_oe <= next_ack;
            ack_state <= next_state; // Frozen so a lock or busy change cannot flip it
          end
        end
      end
    end
  end

  // Store of the non-volatile locations
  pwc_nvmem #(.AW(4), .DW(9)) u_nvmem (
    .i_core_clk(i_core_clk),
    .i_we(mem_we),
    .i_waddr(pend_addr),
    .i_wdata(pend_data),
    .i_raddr(i_avs_address[5:2]),
    .o_rdata(mem_rdata)
  );

  // Register read selection; memory words need a cycle to settle
  always @* begin
    rd_mux = 32'h00000000;
    if (i_avs_address[7:6] == `PWC_OFS_NVMEM) begin
      rd_mux = {23'h000000, mem_rdata};
    end else begin
      case (i_avs_address)
        `PWC_OFS_CFG: rd_mux = {31'h00000000, cfg_eight_bit};
        `PWC_OFS_WIPER0: rd_mux = {23'h000000, o_wiper0};
        `PWC_OFS_WIPER1: rd_mux = {23'h000000, o_wiper1};
        `PWC_OFS_TERMINAL_CONTROL_REGISTER: rd_mux = {23'h000000, o_terminal_control_register};
        `PWC_OFS_STATUS: rd_mux = {27'h0000000, state == ST_ERR, protect, lock1, lock0,
                                   o_eeprom_write_active_flag};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Avalon slave: fixed three-phase answer, waitrequest low one cycle
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph <= 2'h0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      cfg_eight_bit <= `PWC_CFG_RST;
    end else begin
      case (ph)
        2'h0: begin
          if (i_avs_read || i_avs_write) begin
            ph <= 2'h1;
          end
        end
        2'h1: begin
          o_avs_readdata <= i_avs_read ? rd_mux : 32'h00000000;
          o_avs_waitrequest <= 1'b0;
          ph <= 2'h2;
        end
        default: begin
          // Write takes effect at the edge the master sees waitrequest low
          if (i_avs_write && i_avs_byteenable[0] && i_avs_address == `PWC_OFS_CFG) begin
            cfg_eight_bit <= i_avs_writedata[`PWC_CFG_EIGHT_BIT];
          end
          o_avs_waitrequest <= 1'b1;
          ph <= 2'h0;
        end
      endcase
    end
  end

endmodule // pwc_engine
`default_nettype wire

// ==== src/pwc_defines.vh ====
// Purpose: Shared constants of the potentiometer write command engine
// Assumes: Included by bare name from the design files under src/
// Notes: Times in ns, counts derived from the 40 MHz core clock
`ifndef PWC_DEFINES_VH
`define PWC_DEFINES_VH

// Core clock period and programming cycle time
`define PWC_CLK_NS 25
`define PWC_TWC_NS 5000000
`define PWC_TWC_CYCLES ((`PWC_TWC_NS + `PWC_CLK_NS - 1) / `PWC_CLK_NS)

// Command codes in bits 3:2 of the command byte
`define PWC_CMD_WRITE 2'h0
`define PWC_CMD_INC 2'h1
`define PWC_CMD_DEC 2'h2
`define PWC_CMD_READ 2'h3

// Serial memory map
`define PWC_AD_VWIPER0 4'h0
`define PWC_AD_VWIPER1 4'h1
`define PWC_AD_NVWIPER0 4'h2
`define PWC_AD_NVWIPER1 4'h3
`define PWC_AD_TERMINAL_CONTROL_REGISTER 4'h4
`define PWC_AD_STATUS 4'h5
`define PWC_AD_PROTECT 4'hF

// Pending programming job kinds
`define PWC_KIND_DATA 2'h0
`define PWC_KIND_LOCK_SET 2'h1
`define PWC_KIND_LOCK_CLR 2'h2

// Reset values and full-scale wiper codes
`define PWC_WIPER_RST 9'h080
`define PWC_TERMINAL_CONTROL_REGISTER_RST 9'h1FF
`define PWC_FULL_8BIT 9'h100
`define PWC_FULL_7BIT 9'h080

// Avalon byte offsets
`define PWC_OFS_CFG 8'h00
`define PWC_OFS_WIPER0 8'h04
`define PWC_OFS_WIPER1 8'h08
`define PWC_OFS_TERMINAL_CONTROL_REGISTER 8'h0C
`define PWC_OFS_STATUS 8'h10
`define PWC_OFS_NVMEM 2'h1

// Field positions
`define PWC_CFG_EIGHT_BIT 0
`define PWC_ST_EEPROM_WRITE_ACTIVE_FLAG 0
`define PWC_ST_LOCK0 1
`define PWC_ST_LOCK1 2
`define PWC_ST_PROTECT 3
`define PWC_ST_ERROR 4
`define PWC_CFG_RST 1'h1

`endif

// ==== src/pwc_sync2.v ====
// Purpose: Two flip-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are levels, not pulses
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps
`default_nettype none

module pwc_sync2 #(
  parameter WIDTH = 4
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= {WIDTH{1'b1}};
      o_sync <= {WIDTH{1'b1}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // pwc_sync2
`default_nettype wire

// ==== src/pwc_nvmem.v ====
// Purpose: Non-volatile location store, one word per serial address
// Assumes: One write port, one read port, registered read data
// Notes: No reset on contents; they model programmed cells
`timescale 1ns/1ps
`default_nettype none

module pwc_nvmem #(
  parameter AW = 4,
  parameter DW = 9
) (
  input wire i_core_clk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);

  reg [DW-1:0] cells [0:(1<<AW)-1];

  // Write and registered read
  always @(posedge i_core_clk) begin
    if (i_we) begin
      cells[i_waddr] <= i_wdata;
    end
    o_rdata <= cells[i_raddr];
  end

endmodule // pwc_nvmem
`default_nettype wire

// ==== verification/pwc_engine_chk.sv ====
// Purpose: Port-level checker for the write command engine
// Assumes: Single core clock domain, async active-low reset
// Notes: Watches raw pins for Stop; attached by bind below
`timescale 1ns/1ps
`default_nettype none
module pwc_engine_chk #(
  parameter [5:0] SLAVE_ADDR_HI = 6'h2A,
  parameter integer NV_WRITE_CYCLES = 200000
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire [8:0] o_wiper0,
  input wire [8:0] o_wiper1,
  input wire [8:0] o_terminal_control_register,
  input wire o_eeprom_write_active_flag
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  int unsigned hi_cnt;
  logic stop_seen;
  logic scl_q;
  logic sda_q;
  // Flag length counter and Stop tracker; Start clears it so only a fresh Stop counts
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt <= 0;
      stop_seen <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      hi_cnt <= o_eeprom_write_active_flag ? hi_cnt + 1 : 0;
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (scl_q && i_scl && !sda_q && i_sda)
        stop_seen <= 1'b1;
      else if (scl_q && i_scl && sda_q && !i_sda)
        stop_seen <= 1'b0;
    end
  end
  a_open_drain: assert property (o_sda_oe |-> !o_sda_out)
    else $error("sda driven high");
  a_ack_span: assert property ($rose(o_sda_oe) |-> o_sda_oe [*6] ##[1:6] !o_sda_oe)
    else $error("ack pulse length wrong");
  a_vol_in_ack: assert property (!$stable({o_wiper0, o_wiper1, o_terminal_control_register}) |-> o_sda_oe)
    else $error("volatile change outside ack");
  a_flag_length: assert property ($fell(o_eeprom_write_active_flag) |-> hi_cnt == NV_WRITE_CYCLES)
    else $error("programming flag length wrong");
  a_flag_min: assert property ($rose(o_eeprom_write_active_flag) |-> o_eeprom_write_active_flag [*8])
    else $error("programming flag too short");
  a_launch_stop: assert property ($rose(o_eeprom_write_active_flag) |-> stop_seen)
    else $error("programming without Stop");
  a_inc_sat: assert property (!$stable(o_wiper0) && $past(o_wiper0) == 9'h100 |-> o_wiper0 != 9'h101)
    else $error("increment past full scale");
  a_dec_sat: assert property (!$stable(o_wiper0) && $past(o_wiper0) == 9'h000 |-> o_wiper0 != 9'h1FF)
    else $error("decrement wrapped");
  c_prog: cover property ($rose(o_eeprom_write_active_flag));
  c_ack: cover property ($rose(o_sda_oe));
  c_full: cover property (o_wiper0 == 9'h100);
endmodule // pwc_engine_chk
bind pwc_engine pwc_engine_chk #(.SLAVE_ADDR_HI(SLAVE_ADDR_HI), .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_wiper0(o_wiper0), .o_wiper1(o_wiper1),
  .o_terminal_control_register(o_terminal_control_register), .o_eeprom_write_active_flag(o_eeprom_write_active_flag));
`default_nettype wire

// ==== verification/pwc_i2c_host.sv ====
// Purpose: Serial bus master model driving clock and data pins
// Assumes: Pull-up on data, device pulls low through its enable
// Notes: Clock stands high between frames; bit period 200 ns
`timescale 1ns/1ps
`default_nettype none
module pwc_i2c_host (
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic drv_low;
  // Wired bus level; released line floats to the pull-up
  assign o_sda = !(drv_low | i_sda_oe);
  initial begin
    o_scl = 1'b1;
    drv_low = 1'b0;
  end
  // Start or Restart; odd offset keeps edges off the core clock grid
  task automatic start();
    #7;
    drv_low = 1'b0;
    #50 o_scl = 1'b1;
    #50 drv_low = 1'b1;
    #50 o_scl = 1'b0;
    #50;
  endtask
  task automatic bitx(input logic b);
    drv_low = !b;
    #50 o_scl = 1'b1;
    #100 o_scl = 1'b0;
    #50;
  endtask
  // Byte MSB first, then release for the device's acknowledge
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(b[i]);
    drv_low = 1'b0;
    #50 o_scl = 1'b1;
    #50 ack = (o_sda === 1'b0);
    #50 o_scl = 1'b0;
    #50;
  endtask
  // Partial byte, used to cut a frame short
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) bitx(b[i]);
  endtask
  // Stop ends each frame not ended by a Restart, nothing sent between a stored write and it
  task automatic stop();
    drv_low = 1'b1;
    #50 o_scl = 1'b1;
    #50 drv_low = 1'b0;
    #50;
  endtask
endmodule // pwc_i2c_host
`default_nettype wire

// ==== verification/i2c_pot_write_command_engine_tb.sv ====
// Purpose: Self-checking bench for the write command engine
// Assumes: Short programming cycle count for a quick run
// Notes: Registers read over Avalon, serial traffic via host model
`timescale 1ns/1ps
`default_nettype none
module i2c_pot_write_command_engine_tb;
  localparam int NVC = 2000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hv = 1'b0;
  logic a0 = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic scl, sda, sda_out, sda_oe, wq, flag, ack;
  logic [31:0] rdat, got;
  logic [8:0] w0, w1, terminal_control_register;
  int mismatches = 0;
  int comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  pwc_engine #(.NV_WRITE_CYCLES(NVC)) u_dut (.i_core_clk(core_clk), .i_rst_n(rst_n),
    .i_scl(scl), .i_sda(sda), .i_lowest_slave_address_bit(a0),
    .i_high_voltage_command_pin(hv), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .o_wiper0(w0), .o_wiper1(w1), .o_terminal_control_register(terminal_control_register), .o_eeprom_write_active_flag(flag));
  pwc_i2c_host u_host (.i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon access held until waitrequest is seen low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest judged at the rising edge; a waitrequest that never drops is left to the watchdog
    do begin
      @(posedge core_clk);
    end while (wq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  task automatic sethv(input logic v);
    @(posedge core_clk);
    hv <= v;
  endtask
  // Start plus control byte; address bit 0 is h, high when the high-voltage pin or the address strap is high
  task automatic go(input logic h);
    u_host.start();
    u_host.put({6'h2A, h, 1'b0}, ack);
    chk(ack, 1'b1);
  endtask
  // Command byte, optional data byte; e holds the expected acknowledges
  task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic dat,
                     input logic [1:0] e);
    u_host.put(c, ack);
    chk(ack, e[1]);
    if (dat) begin
      u_host.put(d, ack);
      chk(ack, e[0]);
    end
  endtask
  // A flag that never drops is left to the watchdog
  task automatic wait_nv();
    repeat (8) @(posedge core_clk);
    while (flag === 1'b1) begin
      @(posedge core_clk);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdreg(8'h04, 32'h080);
    rdreg(8'h0C, 32'h1FF);
    rdreg(8'h10, 32'h0);
    rdreg(8'hFC, 32'h0);
    $display("test reset done");
    go(1'b0);
    cmd(8'h01, 8'hA5, 1'b1, 2'b11);
    cmd(8'h10, 8'h33, 1'b1, 2'b11);
    cmd(8'h40, 8'hF0, 1'b1, 2'b11);
    go(1'b0);
    u_host.put(8'h00, ack);
    u_host.bits(8'h3C, 4);
    u_host.stop();
    chk({w0, w1, terminal_control_register}, {9'h1A5, 9'h033, 9'h0F0});
    $display("test continuous write done");
    go(1'b0);
    cmd(8'h00, 8'hFF, 1'b1, 2'b11);
    repeat (2) cmd(8'h04, 8'h00, 1'b0, 2'b10);
    chk(w0, 9'h100);
    cmd(8'h00, 8'h01, 1'b1, 2'b11);
    repeat (2) cmd(8'h08, 8'h00, 1'b0, 2'b10);
    chk(w0, 9'h000);
    av(1'b1, 8'h00, 32'h0);
    cmd(8'h10, 8'h7F, 1'b1, 2'b11);
    repeat (2) cmd(8'h14, 8'h00, 1'b0, 2'b10);
    u_host.stop();
    chk(w1, 9'h080);
    av(1'b1, 8'h00, 32'h1);
    rdreg(8'h00, 32'h1);
    $display("test saturation done");
    go(1'b0);
    cmd(8'h20, 8'h55, 1'b1, 2'b11);
    u_host.stop();
    repeat (4) @(posedge core_clk);
    chk(flag, 1'b1);
    go(1'b0);
    cmd(8'h10, 8'h44, 1'b1, 2'b11);
    cmd(8'h30, 8'h12, 1'b1, 2'b00);
    cmd(8'h10, 8'h00, 1'b1, 2'b00);
    rdreg(8'h10, 32'h11);
    u_host.stop();
    chk(w1, 9'h044);
    rdreg(8'h10, 32'h1);
    wait_nv();
    rdreg(8'h48, 32'h055);
    rdreg(8'h10, 32'h0);
    $display("test programming cycle done");
    sethv(1'b1);
    go(1'b1);
    cmd(8'h28, 8'h00, 1'b0, 2'b10);
    u_host.stop();
    wait_nv();
    rdreg(8'h10, 32'h2);
    sethv(1'b0);
    go(1'b0);
    cmd(8'h00, 8'h11, 1'b1, 2'b00);
    u_host.stop();
    chk(w0, 9'h000);
    sethv(1'b1);
    go(1'b1);
    cmd(8'h04, 8'h00, 1'b0, 2'b00);
    u_host.stop();
    go(1'b1);
    cmd(8'h0C, 8'h00, 1'b0, 2'b10);
    u_host.stop();
    rdreg(8'h10, 32'h2);
    go(1'b1);
    cmd(8'h24, 8'h00, 1'b0, 2'b10);
    u_host.stop();
    wait_nv();
    rdreg(8'h10, 32'h0);
    go(1'b1);
    cmd(8'hF8, 8'h00, 1'b0, 2'b10);
    u_host.stop();
    wait_nv();
    rdreg(8'h10, 32'h8);
    sethv(1'b0);
    go(1'b0);
    cmd(8'h60, 8'h12, 1'b1, 2'b00);
    u_host.stop();
    sethv(1'b1);
    go(1'b1);
    cmd(8'hF4, 8'h00, 1'b0, 2'b10);
    u_host.stop();
    wait_nv();
    rdreg(8'h10, 32'h0);
    sethv(1'b0);
    go(1'b0);
    cmd(8'h00, 8'h11, 1'b1, 2'b11);
    u_host.stop();
    chk(w0, 9'h011);
    $display("test lock and protect done");
    @(posedge core_clk);
    a0 <= 1'b1;
    u_host.start();
    u_host.put({6'h2A, 2'b00}, ack);
    chk(ack, 1'b0);
    u_host.stop();
    go(1'b1);
    cmd(8'h10, 8'h21, 1'b1, 2'b11);
    u_host.stop();
    chk(w1, 9'h021);
    $display("test address strap done");
    conclude();
  end
endmodule // i2c_pot_write_command_engine_tb
`default_nettype wire
